// ### dab_glue.sv
// Host glue: decode, timer clocks, trigger select, irq and dma routing
module dab_glue (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire dab_pkg::dab_isa_s isa,
  input wire logic [5:0] base_select_switch,
  input wire logic trigger_source_jumper,
  input wire logic user_clock_jumper,
  input wire logic [3:0] irq_level_jumper,
  input wire logic dma_req_jumper,
  input wire logic dma_ack_jumper,
  input wire logic irq_enable,
  input wire logic dma_enable,
  input wire logic pacer_trigger_mode,
  input wire logic external_trigger_input,
  input wire logic external_user_clock,
  input wire logic pacer_low_out,
  input wire logic pacer_high_out,
  input wire logic [1:0] dack_n,
  input wire logic terminal_count,
  input wire logic adc_done,
  output logic board_sel,
  output logic counter_sel,
  output logic [3:0] reg_index,
  output logic reg_rd,
  output logic reg_wr,
  output logic clk_internal_2m,
  output logic user_counter_clk,
  output logic pacer_low_clk,
  output logic pacer_high_clk,
  output logic adc_start,
  output logic [15:0] irq_out,
  output logic [15:0] irq_oe,
  output logic [1:0] drq_out,
  output logic [1:0] drq_oe
);

  // -----------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------
  localparam int SW = 10 + 3 + 6 + 6;
  logic [SW-1:0] sync_a;
  logic [SW-1:0] sync_b;
  logic [SW-1:0] raw_in;
  assign raw_in = {isa.addr, isa.ior_n, isa.iow_n, isa.aen,
                   base_select_switch, external_trigger_input,
                   external_user_clock, pacer_low_out, pacer_high_out,
                   terminal_count, adc_done};

  // Every pin except the jumpers, enables and pacer_trigger_mode passes two flops; sync_a feeds only sync_b
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync_a <= '1;
      sync_b <= '1;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  logic [1:0] dack_a;
  logic [1:0] dack_s;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dack_a <= 2'h3;
      dack_s <= 2'h3;
    end else begin
      dack_a <= dack_n;
      dack_s <= dack_a;
    end
  end

  logic [9:0] s_addr;
  logic s_ior_n;
  logic s_iow_n;
  logic s_aen;
  logic [5:0] s_sw;
  logic s_ext_trg;
  logic s_ext_clk;
  logic s_low_out;
  logic s_high_out;
  logic s_tc;
  logic s_done;
  assign {s_addr, s_ior_n, s_iow_n, s_aen, s_sw, s_ext_trg, s_ext_clk,
          s_low_out, s_high_out, s_tc, s_done} = sync_b;

  // Previous values for edge detection on synchronised signals
  logic p_ior_n;
  logic p_iow_n;
  logic p_ext_trg;
  logic p_high_out;
  logic p_done;
  logic p_tc;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      p_ior_n <= 1'b1;
      p_iow_n <= 1'b1;
      p_ext_trg <= 1'b1;
      p_high_out <= 1'b1;
      p_done <= 1'b1;
      p_tc <= 1'b1;
    end else begin
      p_ior_n <= s_ior_n;
      p_iow_n <= s_iow_n;
      p_ext_trg <= s_ext_trg;
      p_high_out <= s_high_out;
      p_done <= s_done;
      p_tc <= s_tc;
    end
  end

  // -----------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------
  // Switch ON (1) demands a zero on that address line
  logic base_hit;
  logic io_cycle;
  logic next_sel;
  assign base_hit = (s_addr[9:4] == ~s_sw);
  assign io_cycle = (!s_ior_n || !s_iow_n) && !s_aen;
  assign next_sel = base_hit && io_cycle;

  // Registered select; the low four bits pick one of sixteen slots
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      board_sel <= 1'b0;
      counter_sel <= 1'b0;
      reg_index <= 4'h0;
    end else begin
      board_sel <= next_sel;
      counter_sel <= next_sel && (s_addr[3:0] <= dab_pkg::OFF_CTR_LAST);
      reg_index <= s_addr[3:0];
    end
  end

  // One pulse per strobe's leading edge, only while selected
  logic rd_edge;
  logic wr_edge;
  assign rd_edge = p_ior_n && !s_ior_n && base_hit && !s_aen;
  assign wr_edge = p_iow_n && !s_iow_n && base_hit && !s_aen;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
    end else begin
      // Reads of the counter control slot are reserved
      reg_rd <= rd_edge && (s_addr[3:0] != dab_pkg::OFF_CTR_CTRL);
      reg_wr <= wr_edge;
    end
  end

  // -----------------------------------------------------------------
  // Timer clocks
  // -----------------------------------------------------------------
  // 25 core cycles per period; duty is 12/25, close enough for the chip
  logic [4:0] div_cnt;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_cnt <= 5'h00;
    end else if (div_cnt == 5'(dab_pkg::DIV_CYCLES - 1)) begin
      div_cnt <= 5'h00;
    end else begin
      div_cnt <= div_cnt + 5'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clk_internal_2m <= 1'b0;
    end else begin
      clk_internal_2m <= (div_cnt < 5'(dab_pkg::DIV_HIGH));
    end
  end

  // Counter clocks; low stage output clocks the high stage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      user_counter_clk <= 1'b0;
      pacer_low_clk <= 1'b0;
      pacer_high_clk <= 1'b0;
    end else begin
      user_counter_clk <= user_clock_jumper ? s_ext_clk
                                            : (div_cnt < 5'(dab_pkg::DIV_HIGH));
      pacer_low_clk <= (div_cnt < 5'(dab_pkg::DIV_HIGH));
      pacer_high_clk <= s_low_out;
    end
  end

  // -----------------------------------------------------------------
  // Conversion start
  // -----------------------------------------------------------------
  logic sw_trig;
  logic pacer_trig;
  logic ext_trig;
  logic next_start;
  assign sw_trig = wr_edge && (s_addr[3:0] == dab_pkg::OFF_SW_TRIG);
  assign pacer_trig = !p_high_out && s_high_out;
  assign ext_trig = !p_ext_trg && s_ext_trg;
  always_comb begin
    if (trigger_source_jumper) begin
      next_start = ext_trig;
    end else begin
      next_start = pacer_trigger_mode ? pacer_trig : sw_trig;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      adc_start <= 1'b0;
    end else begin
      adc_start <= next_start;
    end
  end

  // -----------------------------------------------------------------
  // Interrupt
  // -----------------------------------------------------------------
  logic done_edge;
  logic tc_edge;
  logic clr_irq;
  logic irq_flag;
  assign done_edge = !p_done && s_done;
  assign tc_edge = !p_tc && s_tc && !dack_s[dma_ack_jumper];
  assign clr_irq = wr_edge && (s_addr[3:0] == dab_pkg::OFF_CLR_IRQ);

  // Set beats clear so a completion in the clear cycle is kept
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_flag <= 1'b0;
    end else if ((done_edge && !dma_enable) || tc_edge) begin
      irq_flag <= 1'b1;
    end else if (clr_irq) begin
      irq_flag <= 1'b0;
    end
  end

  // Only the one jumpered line is driven; others stay released
  logic [3:0] irq_line;
  assign irq_line = (irq_level_jumper < 4'(dab_pkg::IRQ_CHOICES))
                    ? dab_pkg::IRQ_LINE[irq_level_jumper] : 4'h3;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_out <= 16'h0000;
      irq_oe <= 16'h0000;
    end else begin
      irq_out <= 16'h0000;
      irq_oe <= 16'h0000;
      irq_out[irq_line] <= irq_flag && irq_enable;
      irq_oe[irq_line] <= irq_enable;
    end
  end

  // -----------------------------------------------------------------
  // DMA request
  // -----------------------------------------------------------------
  logic dma_pend;
  logic ack_now;
  assign ack_now = !dack_s[dma_ack_jumper];

  // Request held until acknowledge; a new sample wins over the ack
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dma_pend <= 1'b0;
    end else if (!dma_enable) begin
      dma_pend <= 1'b0;
    end else if (done_edge) begin
      dma_pend <= 1'b1;
    end else if (ack_now) begin
      dma_pend <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      drq_out <= 2'h0;
      drq_oe <= 2'h0;
    end else begin
      drq_out <= 2'h0;
      drq_oe <= 2'h0;
      drq_out[dma_req_jumper] <= dma_pend && dma_enable && !ack_now;
      drq_oe[dma_req_jumper] <= dma_enable;
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  a_sel_needs_io: assert property (@(posedge core_clk)
    disable iff (!rst_n) board_sel |-> $past(io_cycle))
    else $error("select outside an I/O cycle");

  a_sel_base_match: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    board_sel |-> $past(s_addr[9:4]) == ~$past(s_sw))
    else $error("select on wrong base");

  a_ctr_window: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    counter_sel |-> board_sel && reg_index <= dab_pkg::OFF_CTR_LAST)
    else $error("counter select outside its slots");

  a_no_ctrl_read: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    reg_rd |-> reg_index != dab_pkg::OFF_CTR_CTRL || !board_sel)
    else $error("read of counter control slot");

  a_clk_period: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    $rose(clk_internal_2m) |-> ##25 $rose(clk_internal_2m))
    else $error("timer clock period wrong");

  a_pacer_chain: assert property (@(posedge core_clk)
    disable iff (!rst_n) $rose(s_low_out) |=> pacer_high_clk)
    else $error("pacer stages not chained");

  a_irq_gated: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    !irq_enable ##1 !irq_enable |-> irq_out == 16'h0000)
    else $error("interrupt while disabled");

  a_irq_one_line: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    $onehot0(irq_oe) && !irq_oe[0] && !irq_oe[1] && !irq_oe[2])
    else $error("interrupt on illegal line");

  a_dma_gated: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    !dma_enable ##1 !dma_enable |-> drq_out == 2'h0)
    else $error("DMA request while disabled");

  a_tc_irq: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    tc_edge |=> irq_flag ##1 (irq_out[irq_line] || !irq_enable))
    else $error("terminal count raised no interrupt");

  a_ext_start: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    trigger_source_jumper && ext_trig |=> adc_start)
    else $error("external trigger lost");

endmodule

// ### dab_pkg.sv
// Constants and carriers for the data acquisition board host glue
// -----------------------------------------------------------------
// -----------------------------------------------------------------
package dab_pkg;

  // Host bus pins as seen by the board
  typedef struct packed {
    logic [9:0] addr;
    logic ior_n;
    logic iow_n;
    logic aen;
  } dab_isa_s;

  // Window layout
  localparam int unsigned WINDOW_SIZE = 16;
  localparam logic [3:0] OFF_CTR_LAST = 4'h3;
  localparam logic [3:0] OFF_CTR_CTRL = 4'h3;
  localparam logic [3:0] OFF_CLR_IRQ = 4'h8;
  localparam logic [3:0] OFF_SW_TRIG = 4'hC;
  localparam logic [9:0] DEFAULT_BASE = 10'h220;

  // Timer clock derivation
  localparam int unsigned CORE_HZ = 50_000_000;
  localparam int unsigned TIMER_HZ = 2_000_000;
  localparam int unsigned DIV_CYCLES = CORE_HZ / TIMER_HZ;
  localparam int unsigned DIV_HIGH = DIV_CYCLES / 2;

  // Interrupt line for each jumper position
  localparam int unsigned IRQ_CHOICES = 11;
  localparam logic [3:0] IRQ_LINE [IRQ_CHOICES] = '{
    4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF
  };

  // DMA channel index in the request/acknowledge vectors
  localparam int unsigned DMA_CH1 = 0;
  localparam int unsigned DMA_CH3 = 1;

endpackage

// ### dab_host_model.sv
// Host bus and DMA controller model facing the glue block
module dab_host_model (
  input wire logic core_clk,
  output dab_pkg::dab_isa_s isa,
  output logic [1:0] dack_n,
  output logic terminal_count,
  input wire logic [1:0] drq_out,
  input wire logic [1:0] drq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  int ack_wait = 1;
  bit tc_on = 1'b0;
  logic ch;

  // Idle bus at time zero
  initial begin
    isa = '{addr: 10'h000, ior_n: 1'b1, iow_n: 1'b1, aen: 1'b0};
    dack_n = 2'h3;
    terminal_count = 1'b0;
  end

  // Strobe held 4 cycles, idle 4, both above the 3-cycle minimum
  task automatic io(input logic [9:0] a, input logic wr, input logic dma);
    @(negedge core_clk);
    isa.addr = a;
    isa.aen = dma;
    isa.iow_n = ~wr;
    isa.ior_n = wr;
    repeat (4) @(negedge core_clk);
    isa.ior_n = 1'b1;
    isa.iow_n = 1'b1;
    isa.aen = 1'b0;
    // Address is not left at its last value once released
    isa.addr = ~a;
    repeat (4) @(negedge core_clk);
  endtask

  // Acknowledge after a chosen wait, with the window address on the bus
  initial forever begin
    @(negedge core_clk);
    if ((drq_out & drq_oe) != 2'h0) begin
      ch = drq_out[1];
      repeat (ack_wait) @(negedge core_clk);
      dack_n[ch] = 1'b0;
      terminal_count = tc_on;
      io(dab_pkg::DEFAULT_BASE, 1'b0, 1'b1);
      dack_n = 2'h3;
      terminal_count = 1'b0;
    end
  end
endmodule

// ### dab_glue_tb.sv
// Self-checking bench for the host glue block
module dab_glue_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  dab_pkg::dab_isa_s isa;
  logic [5:0] base_select_switch = 6'h1D;
  logic trigger_source_jumper = 1'b0, user_clock_jumper = 1'b0;
  logic [3:0] irq_level_jumper = 4'h0;
  logic dma_req_jumper = 1'b0, dma_ack_jumper = 1'b0;
  logic irq_enable = 1'b0, dma_enable = 1'b0, pacer_trigger_mode = 1'b0;
  logic external_trigger_input = 1'b0, external_user_clock = 1'b0;
  logic pacer_low_out = 1'b0, pacer_high_out = 1'b0, adc_done = 1'b0;
  logic [1:0] dack_n, drq_out, drq_oe;
  logic terminal_count, board_sel, counter_sel, reg_rd, reg_wr;
  logic clk_internal_2m, user_counter_clk, pacer_low_clk, pacer_high_clk;
  logic adc_start, last_cs;
  logic [3:0] reg_index, last_idx;
  logic [15:0] irq_out, irq_oe;
  int bad_count = 0, checked = 0, n_rd = 0, n_wr = 0, n_go = 0, n_sel = 0;
  int lines[11] = '{3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};

  always #10 core_clk = ~core_clk;

  dab_glue uut (.core_clk(core_clk), .rst_n(rst_n), .isa(isa),
    .base_select_switch(base_select_switch),
    .trigger_source_jumper(trigger_source_jumper),
    .user_clock_jumper(user_clock_jumper),
    .irq_level_jumper(irq_level_jumper), .dma_req_jumper(dma_req_jumper),
    .dma_ack_jumper(dma_ack_jumper), .irq_enable(irq_enable),
    .dma_enable(dma_enable), .pacer_trigger_mode(pacer_trigger_mode),
    .external_trigger_input(external_trigger_input),
    .external_user_clock(external_user_clock),
    .pacer_low_out(pacer_low_out), .pacer_high_out(pacer_high_out),
    .dack_n(dack_n), .terminal_count(terminal_count), .adc_done(adc_done),
    .board_sel(board_sel), .counter_sel(counter_sel),
    .reg_index(reg_index), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .clk_internal_2m(clk_internal_2m), .user_counter_clk(user_counter_clk),
    .pacer_low_clk(pacer_low_clk), .pacer_high_clk(pacer_high_clk),
    .adc_start(adc_start), .irq_out(irq_out), .irq_oe(irq_oe),
    .drq_out(drq_out), .drq_oe(drq_oe));

  dab_host_model host (.core_clk(core_clk), .isa(isa), .dack_n(dack_n),
    .terminal_count(terminal_count), .drq_out(drq_out), .drq_oe(drq_oe));

  // Pulse counters sampled mid-cycle, where outputs have settled
  always @(negedge core_clk) begin
    if (reg_rd === 1'b1) n_rd++;
    if (reg_wr === 1'b1) n_wr++;
    if (adc_start === 1'b1) n_go++;
    if (board_sel === 1'b1) begin
      n_sel++;
      last_idx = reg_index;
      last_cs = counter_sel;
    end
  end

  // -------------------------------------------------------------
  // Shared helpers
  // -------------------------------------------------------------
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Held well past the 3-flop input path so the edge is seen
  task automatic pulse(ref logic p);
    p = 1'b1;
    repeat (4) @(negedge core_clk);
    p = 1'b0;
    repeat (8) @(negedge core_clk);
  endtask

  // Rising edges of one clock output over 10 periods of the 2 MHz clock
  task automatic rises(int sel, int tog, output int r);
    logic [3:0] v, p;
    r = 0;
    p = {pacer_low_clk, pacer_high_clk, user_counter_clk, clk_internal_2m};
    for (int i = 0; i < 250; i++) begin
      @(negedge core_clk);
      if (tog > 0 && i % tog == 0 && i < 240) begin
        external_user_clock = ~external_user_clock;
        pacer_low_out = ~pacer_low_out;
      end
      v = {pacer_low_clk, pacer_high_clk, user_counter_clk, clk_internal_2m};
      if (v[sel] && !p[sel]) r++;
      p = v;
    end
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_decode(logic [5:0] sw, logic [9:0] base);
    int s, w, r;
    logic hit;
    base_select_switch = sw;
    repeat (4) @(negedge core_clk);
    // One below and one above the window must stay silent
    for (int o = -1; o <= 16; o++) begin
      s = n_sel;
      w = n_wr;
      r = n_rd;
      hit = (o >= 0 && o < 16);
      host.io(base + 10'(o), 1'b1, 1'b0);
      host.io(base + 10'(o), 1'b0, 1'b0);
      chk("select", 16'(n_sel > s), 16'(hit));
      chk("write", 16'(n_wr - w), 16'(hit));
      chk("read", 16'(n_rd - r), 16'(hit && o != 3));
      if (hit) chk("index", 16'(last_idx), 16'(o));
      if (hit) chk("ctr sel", 16'(last_cs), 16'(o < 4));
    end
    s = n_sel;
    host.io(base, 1'b1, 1'b1);
    chk("aen sel", 16'(n_sel - s), 16'h0000);
  endtask

  task automatic t_trig;
    int g;
    g = n_go;
    host.io(10'h22C, 1'b1, 1'b0);
    chk("soft trig", 16'(n_go - g), 16'h0001);
    pacer_trigger_mode = 1'b1;
    g = n_go;
    pulse(pacer_high_out);
    chk("pacer trig", 16'(n_go - g), 16'h0001);
    trigger_source_jumper = 1'b1;
    g = n_go;
    pulse(pacer_high_out);
    pulse(external_trigger_input);
    chk("ext trig", 16'(n_go - g), 16'h0001);
    trigger_source_jumper = 1'b0;
    pacer_trigger_mode = 1'b0;
  endtask

  task automatic t_irq;
    irq_enable = 1'b1;
    for (int j = 0; j < 11; j++) begin
      irq_level_jumper = 4'(j);
      pulse(adc_done);
      chk("irq out", irq_out, 16'h0001 << lines[j]);
      chk("irq oe", irq_oe, 16'h0001 << lines[j]);
      host.io(10'h228, 1'b1, 1'b0);
      chk("irq clear", irq_out, 16'h0000);
    end
    irq_enable = 1'b0;
    pulse(adc_done);
    chk("irq off", irq_out | irq_oe, 16'h0000);
    host.io(10'h228, 1'b1, 1'b0);
  endtask

  task automatic t_dma;
    int k, s;
    irq_level_jumper = 4'h0;
    irq_enable = 1'b1;
    dma_enable = 1'b1;
    // Prompt acknowledge on channel 1, slow one with terminal count on 3
    for (int c = 0; c < 2; c++) begin
      dma_req_jumper = c[0];
      dma_ack_jumper = c[0];
      host.ack_wait = 1 + 6 * c;
      host.tc_on = c[0];
      s = n_sel;
      adc_done = 1'b1;
      for (k = 0; k < 20 && drq_out[c] !== 1'b1; k++) @(negedge core_clk);
      adc_done = 1'b0;
      if (k == 20) begin
        chk("drq wait", 16'(drq_out[c]), 16'h0001);
        give_verdict;
      end
      chk("drq", 16'({drq_oe, drq_out}), 16'(5 << c));
      repeat (30) @(negedge core_clk);
      chk("drq done", 16'(drq_out), 16'h0000);
      chk("dma sel", 16'(n_sel - s), 16'h0000);
      chk("tc irq", irq_out, c ? 16'h0008 : 16'h0000);
    end
    dma_enable = 1'b0;
    pulse(adc_done);
    chk("no drq", 16'(drq_out | drq_oe), 16'h0000);
    host.io(10'h228, 1'b1, 1'b0);
  endtask

  task automatic t_clk;
    int r;
    rises(0, 0, r);
    chk("2m rises", 16'(r), 16'd10);
    rises(1, 0, r);
    chk("user int", 16'(r), 16'd10);
    rises(3, 0, r);
    chk("pacer low", 16'(r), 16'd10);
    user_clock_jumper = 1'b1;
    repeat (4) @(negedge core_clk);
    rises(1, 25, r);
    chk("user ext", 16'(r), 16'd5);
    rises(2, 25, r);
    chk("pacer clk", 16'(r), 16'd5);
  endtask

  // Main sequence: reset for 4 cycles, then every scenario
  initial begin
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    t_decode(6'h0F, 10'h300);
    t_decode(6'h1D, 10'h220);
    t_trig;
    t_irq;
    t_dma;
    t_clk;
    give_verdict;
  end
endmodule
